// ===== dma_channel_register_set.sv
// Behaviour
// RQ1 - seventeen registers: four per channel plus shared
// RQ2 - source address read/write, counts during transfer
// RQ3 - destination address read/write, counts during transfer
// RQ4 - single mode: source ignored when device sources
// RQ5 - single mode: destination ignored when device sinks
// RQ6 - software keeps addresses aligned to unit size
// RQ7 - half-word write keeps the other half
// RQ8 - address and count registers have no reset
// RQ9 - low 24 count bits; zero means maximum
// RQ10 - count shows transfers still remaining
// RQ11 - count upper eight bits read zero
// RQ12 - control bits 31..21 read zero
// RQ13 - bit 20 pointer mode, channel 3 only
// RQ14 - bit 19 source reload, channel 2 only
// RQ15 - bit 18 ack polarity, channels 0/1 only
// RQ16 - channels 0/1 drive request-sampled acknowledge
// RQ17 - external request by falling edge or low
// RQ18 - count decrements per unit, stops at zero
//
// Chosen here: strobed register access and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module dma_channel_register_set
  import dma_regs_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [dma_regs_pkg::ADDR_W-1:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic [1:0] regWrHalf,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  input wire logic [1:0] externalTransferRequestN,
  output logic [1:0] transferStrobe,
  output logic [1:0] requestSampledAck,
  output logic [3:0] channelDone
);
  import dma_regs_pkg::*;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] mergeHalf(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [1:0] half);
    mergeHalf = {half[1] ? nw[31:16] : old[31:16], half[0] ? nw[15:0] : old[15:0]};
  endfunction : mergeHalf

  function automatic logic [CTRL_W-1:0] ctrlMask(input int ch);
    ctrlMask = MASK_COMMON;
    if (ch < 2)
      ctrlMask = ctrlMask | MASK_EXT_ONLY;
    if (ch == 2)
      ctrlMask = ctrlMask | MASK_CH2_ONLY;
    if (ch == 3)
      ctrlMask = ctrlMask | MASK_CH3_ONLY;
  endfunction : ctrlMask

  function automatic logic hitReg(input logic [ADDR_W-1:0] a, input int ch,
                                  input logic [7:0] off);
    hitReg = (a == 8'(CH_STRIDE * ch) + off);
  endfunction : hitReg

  function automatic logic [31:0] stepAddr(input logic [31:0] a, input logic [1:0] mode,
                                           input logic [1:0] size);
    logic [31:0] step;
    step = (size == SIZE_LONG) ? 32'h00000004 : (size == SIZE_WORD) ? 32'h00000002
         : 32'h00000001;
    case (mode)
      ADDR_INC: stepAddr = a + step;
      ADDR_DEC: stepAddr = a - step;
      default: stepAddr = a;
    endcase
  endfunction : stepAddr

  // ****************************************
  // state
  // ****************************************
  logic [31:0] srcAddr_ff [CHANNELS];
  logic [31:0] srcInit_ff [CHANNELS];
  logic [31:0] dstAddr_ff [CHANNELS];
  logic [COUNT_W-1:0] count_ff [CHANNELS];
  logic [CTRL_W-1:0] ctrl_ff [CHANNELS];
  logic masterEnable_ff;
  logic [1:0] reqMeta_ff;
  logic [1:0] reqSync_ff;
  logic [1:0] reqPrev_ff;
  logic [31:0] regRdata_ff;
  logic [1:0] transferStrobe_ff;
  logic [1:0] requestSampledAck_ff;
  logic [3:0] channelDone_ff;
  logic [3:0] request;
  logic [3:0] go;
  logic [3:0] lastUnit;
  logic wrShared;

  assign wrShared = regWr && (regAddr == OFF_SHARED_OPERATION_CONTROL);

  // ****************************************
  // external request synchroniser
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      reqMeta_ff <= 2'h3;
      reqSync_ff <= 2'h3;
      reqPrev_ff <= 2'h3;
    end
    else
    begin
      reqMeta_ff <= externalTransferRequestN;
      reqSync_ff <= reqMeta_ff;
      reqPrev_ff <= reqSync_ff;
    end
  end

  // ****************************************
  // request and go per channel
  // ****************************************
  always_comb
  begin
    for (int ch = 0; ch < CHANNELS; ch++)
    begin
      request[ch] = 1'b1;
      if (ch < 2 && ctrl_ff[ch][BIT_EXT_REQUEST_SELECT])
      begin
        // RQ17 falling edge or low
        request[ch] = ctrl_ff[ch][BIT_REQUEST_EDGE] ? (reqPrev_ff[ch] && !reqSync_ff[ch])
                                                    : !reqSync_ff[ch];
      end
      // RQ18 stop once done
      go[ch] = masterEnable_ff && ctrl_ff[ch][BIT_CHANNEL_ENABLE]
            && !ctrl_ff[ch][BIT_TRANSFER_END] && request[ch];
      // RQ9 zero counts as maximum
      lastUnit[ch] = go[ch] && (count_ff[ch] == COUNT_LAST);
    end
  end

  // ****************************************
  // source address
  // ****************************************
  // no reset: contents undefined until software writes them
  // RQ8 undefined after reset
  always_ff @(posedge clk)
  begin
    for (int ch = 0; ch < CHANNELS; ch++)
    begin
      if (regWr && hitReg(regAddr, ch, OFF_SOURCE_ADDRESS))
      begin
        // RQ7 half-word merge
        srcAddr_ff[ch] <= mergeHalf(srcAddr_ff[ch], regWdata, regWrHalf);
        srcInit_ff[ch] <= mergeHalf(srcAddr_ff[ch], regWdata, regWrHalf);
      end
      else if (go[ch])
      begin
        // RQ4 single mode source ignored
        if (ch < 2 && ctrl_ff[ch][BIT_SINGLE_ADDRESS] && ctrl_ff[ch][BIT_DEVICE_IS_SOURCE])
          srcAddr_ff[ch] <= srcAddr_ff[ch];
        // RQ14 channel 2 reload
        else if (ch == 2 && ctrl_ff[ch][BIT_SOURCE_RELOAD_ENABLE])
          srcAddr_ff[ch] <= srcInit_ff[ch];
        // RQ13 pointer walks by one longword
        else if (ch == 3 && ctrl_ff[ch][BIT_CH3_POINTER_MODE])
          srcAddr_ff[ch] <= srcAddr_ff[ch] + POINTER_STEP;
        // RQ2 source counts
        else
          srcAddr_ff[ch] <= stepAddr(srcAddr_ff[ch],
                                     ctrl_ff[ch][BIT_SOURCE_MODE_LO +: 2],
                                     ctrl_ff[ch][BIT_SIZE_LO +: 2]);
      end
    end
  end

  // ****************************************
  // destination address
  // ****************************************
  always_ff @(posedge clk)
  begin
    for (int ch = 0; ch < CHANNELS; ch++)
    begin
      if (regWr && hitReg(regAddr, ch, OFF_DESTINATION_ADDRESS))
        dstAddr_ff[ch] <= mergeHalf(dstAddr_ff[ch], regWdata, regWrHalf);
      // RQ5 single mode destination ignored
      else if (go[ch] && !(ch < 2 && ctrl_ff[ch][BIT_SINGLE_ADDRESS]
                           && !ctrl_ff[ch][BIT_DEVICE_IS_SOURCE]))
        // RQ3 destination counts
        dstAddr_ff[ch] <= stepAddr(dstAddr_ff[ch], ctrl_ff[ch][BIT_DEST_MODE_LO +: 2],
                                   ctrl_ff[ch][BIT_SIZE_LO +: 2]);
    end
  end

  // ****************************************
  // transfer count
  // ****************************************
  always_ff @(posedge clk)
  begin
    for (int ch = 0; ch < CHANNELS; ch++)
    begin
      if (regWr && hitReg(regAddr, ch, OFF_TRANSFER_COUNT))
        // RQ11 upper byte dropped
        count_ff[ch] <= COUNT_W'(mergeHalf({8'h00, count_ff[ch]}, regWdata, regWrHalf));
      // RQ10 remaining transfers
      else if (go[ch])
        count_ff[ch] <= count_ff[ch] - COUNT_LAST;
    end
  end

  // ****************************************
  // channel and shared control
  // ****************************************
  always_ff @(posedge clk)
  begin
    for (int ch = 0; ch < CHANNELS; ch++)
    begin
      if (!rst_n)
        ctrl_ff[ch] <= CTRL_RESET;
      else
      begin
        if (regWr && hitReg(regAddr, ch, OFF_CHANNEL_CONTROL))
          // RQ12 RQ13 RQ14 RQ15 unimplemented bits kept zero
          ctrl_ff[ch] <= CTRL_W'(mergeHalf({11'h000, ctrl_ff[ch]}, regWdata, regWrHalf))
                       & ctrlMask(ch);
        // a finishing unit beats a software clear of the end flag
        if (lastUnit[ch])
          ctrl_ff[ch][BIT_TRANSFER_END] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      masterEnable_ff <= 1'b0;
    else if (wrShared && regWrHalf[0])
      masterEnable_ff <= regWdata[BIT_MASTER_ENABLE];
  end

  // ****************************************
  // read port
  // ****************************************
  // RQ1 seventeen registers decoded
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      regRdata_ff <= 32'h00000000;
    else
    begin
      regRdata_ff <= 32'h00000000;
      if (regRd)
      begin
        if (regAddr == OFF_SHARED_OPERATION_CONTROL)
          regRdata_ff <= {31'h00000000, masterEnable_ff};
        for (int ch = 0; ch < CHANNELS; ch++)
        begin
          if (hitReg(regAddr, ch, OFF_SOURCE_ADDRESS))
            regRdata_ff <= srcAddr_ff[ch];
          if (hitReg(regAddr, ch, OFF_DESTINATION_ADDRESS))
            regRdata_ff <= dstAddr_ff[ch];
          // RQ11 upper count bits zero
          if (hitReg(regAddr, ch, OFF_TRANSFER_COUNT))
            regRdata_ff <= {8'h00, count_ff[ch]} & COUNT_READ_MASK;
          // RQ12 reserved read zero
          if (hitReg(regAddr, ch, OFF_CHANNEL_CONTROL))
            regRdata_ff <= {11'h000, ctrl_ff[ch]};
        end
      end
    end
  end

  // ****************************************
  // pins toward external devices
  // ****************************************
  // polarity bits double as the idle level, so a switch takes effect at once
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      transferStrobe_ff <= 2'h0;
      requestSampledAck_ff <= 2'h0;
    end
    else
    begin
      for (int ch = 0; ch < 2; ch++)
      begin
        transferStrobe_ff[ch] <= go[ch] ^ ctrl_ff[ch][BIT_STROBE_POLARITY];
        // RQ15 RQ16 sampled acknowledge with polarity
        requestSampledAck_ff[ch] <= (go[ch] && ctrl_ff[ch][BIT_EXT_REQUEST_SELECT])
                                    ^ ctrl_ff[ch][BIT_REQUEST_ACK_POLARITY];
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      channelDone_ff <= 4'h0;
    else
      for (int ch = 0; ch < CHANNELS; ch++)
        channelDone_ff[ch] <= ctrl_ff[ch][BIT_TRANSFER_END];
  end

  assign regRdata = regRdata_ff;
  assign transferStrobe = transferStrobe_ff;
  assign requestSampledAck = requestSampledAck_ff;
  assign channelDone = channelDone_ff;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_count_upper_zero: assert property ( // RQ11
    regRd && regAddr == OFF_TRANSFER_COUNT |=> regRdata[31:24] == 8'h00)
    else $error("count upper byte not zero");
  a_ctrl_reserved_zero: assert property ( // RQ12
    regRd && regAddr[3:0] == OFF_CHANNEL_CONTROL[3:0] |=> regRdata[31:21] == 11'h000)
    else $error("control reserved bits not zero");
  a_pointer_mode_ch3: assert property ( // RQ13
    regRd && regAddr == 8'h2c |=> regRdata[20] == 1'b0)
    else $error("pointer mode visible outside channel 3");
  a_reload_ch2: assert property ( // RQ14
    regRd && regAddr == 8'h3c |=> regRdata[19] == 1'b0)
    else $error("reload bit visible outside channel 2");
  a_ack_pol_ch01: assert property ( // RQ15
    regRd && regAddr == 8'h2c |=> regRdata[18] == 1'b0)
    else $error("ack polarity visible in channel 2");
  a_count_decrements: assert property ( // RQ10
    go[0] && !(regWr && regAddr == OFF_TRANSFER_COUNT)
    |=> count_ff[0] == $past(count_ff[0]) - COUNT_LAST)
    else $error("count did not decrement");
  a_stop_at_end: assert property ( // RQ18
    lastUnit[1] |=> !go[1] [*2])
    else $error("channel kept going after last unit");
  a_half_write: assert property ( // RQ7
    regWr && regWrHalf == 2'b01 && regAddr == OFF_SOURCE_ADDRESS
    |=> srcAddr_ff[0][31:16] == $past(srcAddr_ff[0][31:16]))
    else $error("untouched half changed");
  a_sampled_ack: assert property ( // RQ16
    go[0] && ctrl_ff[0][BIT_EXT_REQUEST_SELECT]
    |=> requestSampledAck[0] != $past(ctrl_ff[0][BIT_REQUEST_ACK_POLARITY]))
    else $error("sampled acknowledge missing");
  a_single_src_hold: assert property ( // RQ4
    go[1] && ctrl_ff[1][BIT_SINGLE_ADDRESS] && ctrl_ff[1][BIT_DEVICE_IS_SOURCE]
    && !regWr |=> $stable(srcAddr_ff[1]))
    else $error("ignored source address moved");

  c_last_unit: cover property (lastUnit[0] ##1 channelDone_ff[0] == 1'b0);
  c_edge_request: cover property (go[0] && ctrl_ff[0][BIT_REQUEST_EDGE]);
  c_reload: cover property (go[2] && ctrl_ff[2][BIT_SOURCE_RELOAD_ENABLE]);
  c_back_to_back: cover property (regWr ##1 regRd);
endmodule : dma_channel_register_set
`default_nettype wire

// ===== dma_regs_pkg.sv
package dma_regs_pkg;
  localparam int unsigned CHANNELS = 4;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned COUNT_W = 24;
  localparam int unsigned CTRL_W = 21;
  // ****************************************
  // register map, byte addresses
  // ****************************************
  localparam logic [7:0] CH_STRIDE = 8'h10;
  localparam logic [7:0] OFF_SOURCE_ADDRESS = 8'h00;
  localparam logic [7:0] OFF_DESTINATION_ADDRESS = 8'h04;
  localparam logic [7:0] OFF_TRANSFER_COUNT = 8'h08;
  localparam logic [7:0] OFF_CHANNEL_CONTROL = 8'h0c;
  localparam logic [7:0] OFF_SHARED_OPERATION_CONTROL = 8'h40;
  // ****************************************
  // channel control fields
  // ****************************************
  localparam int unsigned BIT_CHANNEL_ENABLE = 0;
  localparam int unsigned BIT_TRANSFER_END = 1;
  localparam int unsigned BIT_EXT_REQUEST_SELECT = 2;
  localparam int unsigned BIT_REQUEST_EDGE = 3;
  localparam int unsigned BIT_SIZE_LO = 4;
  localparam int unsigned BIT_SINGLE_ADDRESS = 6;
  localparam int unsigned BIT_DEVICE_IS_SOURCE = 7;
  localparam int unsigned BIT_SOURCE_MODE_LO = 12;
  localparam int unsigned BIT_DEST_MODE_LO = 14;
  localparam int unsigned BIT_STROBE_POLARITY = 16;
  localparam int unsigned BIT_REQUEST_ACK_POLARITY = 18;
  localparam int unsigned BIT_SOURCE_RELOAD_ENABLE = 19;
  localparam int unsigned BIT_CH3_POINTER_MODE = 20;
  localparam int unsigned BIT_MASTER_ENABLE = 0;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 21'h000000;
  localparam logic [CTRL_W-1:0] MASK_COMMON = 21'h03f0ff;
  localparam logic [CTRL_W-1:0] MASK_EXT_ONLY = 21'h0700cc;
  localparam logic [CTRL_W-1:0] MASK_CH2_ONLY = 21'h080000;
  localparam logic [CTRL_W-1:0] MASK_CH3_ONLY = 21'h100000;
  localparam logic [31:0] COUNT_READ_MASK = 32'h00ffffff;
  localparam logic [COUNT_W-1:0] COUNT_LAST = 24'h000001;
  localparam logic [31:0] POINTER_STEP = 32'h00000004;
  typedef enum logic [1:0] {
    SIZE_BYTE = 2'b00,
    SIZE_WORD = 2'b01,
    SIZE_LONG = 2'b10,
    SIZE_RSVD = 2'b11
  } unit_size_t;
  typedef enum logic [1:0] {
    ADDR_FIXED = 2'b00,
    ADDR_INC = 2'b01,
    ADDR_DEC = 2'b10,
    ADDR_BAD = 2'b11
  } addr_mode_t;
endpackage : dma_regs_pkg

// ===== ext_request_device.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// external requester on channels 0 and 1
// ****************************************
module ext_request_device
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic listen,
  input wire logic [1:0] request,
  input wire logic [1:0] ackLow,
  input wire logic [1:0] transferStrobe,
  input wire logic [1:0] requestSampledAck,
  output logic [1:0] externalTransferRequestN,
  output logic [15:0] ackSeen,
  output logic [15:0] strobeSeen
);
  // active-low request pin
  // pin goes back high when released, as a pulled-up line would
  assign externalTransferRequestN = ~request;
  // count acks at level
  // counting is gated because the idle level moves when polarity is written
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ackSeen <= 16'h0000;
      strobeSeen <= 16'h0000;
    end
    else if (listen)
    begin
      for (int i = 0; i < 2; i++)
      begin
        ackSeen[i*8 +: 8] <= ackSeen[i*8 +: 8] + {7'h00, requestSampledAck[i] != ackLow[i]};
        strobeSeen[i*8 +: 8] <= strobeSeen[i*8 +: 8] + {7'h00, transferStrobe[i]};
      end
    end
  end
endmodule : ext_request_device
`default_nettype wire

// ===== dma_channel_register_set_tb.sv
`timescale 1ns/1ps
`default_nettype none
module dma_channel_register_set_tb;
  import dma_regs_pkg::*;
  logic clk;
  logic rst_n;
  logic [7:0] regAddr;
  logic [31:0] regWdata;
  logic [1:0] regWrHalf;
  logic regWr;
  logic regRd;
  logic [31:0] regRdata;
  logic [1:0] externalTransferRequestN;
  logic [1:0] transferStrobe;
  logic [1:0] requestSampledAck;
  logic [3:0] channelDone;
  logic listen;
  logic [1:0] request;
  logic [1:0] ackLow;
  logic [15:0] ackSeen;
  logic [15:0] strobeSeen;
  int nMismatch;
  int samplesChecked;

  dma_channel_register_set dma_channel_register_set_inst (
    .clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
    .regWrHalf(regWrHalf), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .externalTransferRequestN(externalTransferRequestN), .transferStrobe(transferStrobe),
    .requestSampledAck(requestSampledAck), .channelDone(channelDone));

  ext_request_device ext_request_device_inst (
    .clk(clk), .rst_n(rst_n), .listen(listen), .request(request), .ackLow(ackLow),
    .transferStrobe(transferStrobe), .requestSampledAck(requestSampledAck),
    .externalTransferRequestN(externalTransferRequestN), .ackSeen(ackSeen),
    .strobeSeen(strobeSeen));

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic summarize();
    if (nMismatch == 0 && samplesChecked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : summarize

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp)
    begin
      nMismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  function automatic logic [7:0] ra(input int ch, input logic [7:0] off);
    return 8'(ch) * CH_STRIDE + off;
  endfunction : ra

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] h);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWrHalf <= h;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask : wr

  task automatic rdChk(input logic [7:0] a, input logic [31:0] exp, input string what);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    chk(what, regRdata, exp);
  endtask : rdChk

  task automatic waitDone(input int idx);
    int n;
    n = 0;
    while (channelDone[idx] !== 1'b1 && n < 500)
    begin
      @(posedge clk);
      n++;
    end
    if (channelDone[idx] !== 1'b1)
    begin
      nMismatch++;
      summarize();
    end
  endtask : waitDone

  // ****************************************
  // scenarios
  // ****************************************
  task automatic resetCheck();
    for (int ch = 0; ch < 4; ch++)
      rdChk(ra(ch, OFF_CHANNEL_CONTROL), 32'h00000000, "control reset");
    rdChk(OFF_SHARED_OPERATION_CONTROL, 32'h00000000, "shared reset");
  endtask : resetCheck

  task automatic halfWrite();
    wr(ra(0, OFF_SOURCE_ADDRESS), 32'h12345678, 2'b11);
    wr(ra(0, OFF_SOURCE_ADDRESS), 32'haaaabbbb, 2'b01);
    rdChk(ra(0, OFF_SOURCE_ADDRESS), 32'h1234bbbb, "src low half");
    wr(ra(1, OFF_DESTINATION_ADDRESS), 32'h11112222, 2'b11);
    wr(ra(1, OFF_DESTINATION_ADDRESS), 32'hccccdddd, 2'b10);
    rdChk(ra(1, OFF_DESTINATION_ADDRESS), 32'hcccc2222, "dst high half");
    wr(ra(1, OFF_TRANSFER_COUNT), 32'h00abcdef, 2'b11);
    wr(ra(1, OFF_TRANSFER_COUNT), 32'h00120000, 2'b10);
    rdChk(ra(1, OFF_TRANSFER_COUNT), 32'h0012cdef, "count half");
    wr(8'h44, 32'h0000ffff, 2'b11);
    rdChk(8'h44, 32'h00000000, "unmapped");
    rdChk(8'h80, 32'h00000000, "unmapped");
  endtask : halfWrite

  task automatic autoRun();
    wr(ra(2, OFF_SOURCE_ADDRESS), 32'h00001000, 2'b11);
    wr(ra(2, OFF_DESTINATION_ADDRESS), 32'h00002000, 2'b11);
    wr(ra(2, OFF_TRANSFER_COUNT), 32'h00000003, 2'b11);
    wr(ra(2, OFF_CHANNEL_CONTROL), 32'h00085011, 2'b11);
    wr(ra(3, OFF_SOURCE_ADDRESS), 32'h00003000, 2'b11);
    wr(ra(3, OFF_DESTINATION_ADDRESS), 32'h00004000, 2'b11);
    wr(ra(3, OFF_TRANSFER_COUNT), 32'h00000002, 2'b11);
    wr(ra(3, OFF_CHANNEL_CONTROL), 32'h00109001, 2'b11);
    wr(OFF_SHARED_OPERATION_CONTROL, 32'h00000001, 2'b11);
    waitDone(2);
    waitDone(3);
    rdChk(ra(2, OFF_SOURCE_ADDRESS), 32'h00001000, "ch2 src");
    rdChk(ra(2, OFF_DESTINATION_ADDRESS), 32'h00002006, "ch2 dst");
    rdChk(ra(2, OFF_TRANSFER_COUNT), 32'h00000000, "ch2 count");
    rdChk(ra(2, OFF_CHANNEL_CONTROL), 32'h00085013, "ch2 ctrl");
    rdChk(ra(3, OFF_SOURCE_ADDRESS), 32'h00003008, "ch3 src");
    rdChk(ra(3, OFF_DESTINATION_ADDRESS), 32'h00003ffe, "ch3 dst");
    rdChk(ra(3, OFF_TRANSFER_COUNT), 32'h00000000, "ch3 count");
    rdChk(ra(3, OFF_CHANNEL_CONTROL), 32'h00109003, "ch3 ctrl");
  endtask : autoRun

  task automatic extRun();
    wr(ra(0, OFF_SOURCE_ADDRESS), 32'h00005000, 2'b11);
    wr(ra(0, OFF_DESTINATION_ADDRESS), 32'h00006000, 2'b11);
    wr(ra(0, OFF_TRANSFER_COUNT), 32'h00000004, 2'b11);
    wr(ra(0, OFF_CHANNEL_CONTROL), 32'h00045065, 2'b11);
    wr(ra(1, OFF_SOURCE_ADDRESS), 32'h00007000, 2'b11);
    wr(ra(1, OFF_DESTINATION_ADDRESS), 32'h00008000, 2'b11);
    wr(ra(1, OFF_TRANSFER_COUNT), 32'h00000001, 2'b11);
    wr(ra(1, OFF_CHANNEL_CONTROL), 32'h000050dd, 2'b11);
    @(posedge clk);
    listen <= 1'b1;
    request <= 2'b01;
    waitDone(0);
    request <= 2'b00;
    // second pulse lands after the count is spent and must be ignored
    for (int k = 0; k < 2; k++)
    begin
      @(posedge clk);
      request <= 2'b10;
      repeat (6) @(posedge clk);
      request <= 2'b00;
      repeat (12) @(posedge clk);
    end
    chk("ch0 acks", {24'h0, ackSeen[7:0]}, 32'h4);
    chk("ch0 strobes", {24'h0, strobeSeen[7:0]}, 32'h4);
    chk("ch0 ack idle", {31'h0, requestSampledAck[0]}, 32'h1);
    chk("ch1 acks", {24'h0, ackSeen[15:8]}, 32'h1);
    chk("ch1 strobes", {24'h0, strobeSeen[15:8]}, 32'h1);
    chk("ch1 done", {31'h0, channelDone[1]}, 32'h1);
    rdChk(ra(0, OFF_SOURCE_ADDRESS), 32'h00005010, "ch0 src");
    rdChk(ra(0, OFF_DESTINATION_ADDRESS), 32'h00006000, "ch0 dst");
    rdChk(ra(0, OFF_TRANSFER_COUNT), 32'h00000000, "ch0 count");
    rdChk(ra(1, OFF_SOURCE_ADDRESS), 32'h00007000, "ch1 src");
    rdChk(ra(1, OFF_DESTINATION_ADDRESS), 32'h00008002, "ch1 dst");
    listen <= 1'b0;
  endtask : extRun

  task automatic bitMask();
    logic [31:0] e [4];
    e = '{32'h00040000, 32'h00040000, 32'h00080000, 32'h00100000};
    for (int ch = 0; ch < 4; ch++)
    begin
      wr(ra(ch, OFF_CHANNEL_CONTROL), 32'h001c0000, 2'b11);
      rdChk(ra(ch, OFF_CHANNEL_CONTROL), e[ch], "control bits");
    end
  endtask : bitMask

  initial
  begin
    rst_n = 1'b0;
    regAddr = 8'h00;
    regWdata = 32'h00000000;
    regWrHalf = 2'b00;
    regWr = 1'b0;
    regRd = 1'b0;
    listen = 1'b0;
    request = 2'b00;
    ackLow = 2'b01;
    nMismatch = 0;
    samplesChecked = 0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    resetCheck();
    halfWrite();
    autoRun();
    extRun();
    bitMask();
    summarize();
  end
endmodule : dma_channel_register_set_tb
`default_nettype wire
